// ### design/encoder_counter_cfg.svh
`ifndef ENCODER_COUNTER_CFG_SVH
`define ENCODER_COUNTER_CFG_SVH

// ----------------------------------------------------------------------------
// Clock and filter times
// ----------------------------------------------------------------------------
`define CLK_MHZ 25
`define FILT_FAST_US 10
`define FILT_SLOW_US 50
`define FILT_GEN_MS 10
`define FILT_FAST_CYC (`FILT_FAST_US * `CLK_MHZ)
`define FILT_SLOW_CYC (`FILT_SLOW_US * `CLK_MHZ)
`define FILT_GEN_CYC (`FILT_GEN_MS * 1000 * `CLK_MHZ)
`define FILT_W 18
// Inputs 2, 6 and 7 use the slower counter filter; input 5 is never a counter input, so its mask bit has no effect.
`define SLOW_FILT_MASK 8'he4

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_SINGLE 8'h08
`define OFS_DUAL 8'h0c
`define OFS_QUAD 8'h10
`define OFS_OUT 8'h14

// ----------------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------------
`define CTRL_EN_SINGLE 0
`define CTRL_EN_DUAL 1
`define CTRL_EN_QUAD 2
`define CTRL_FN_CHANGE 3
`define CTRL_RST_DROP 4
`define CTRL_REMAP 5
`define CTRL_DIR_LSB 16
`define NUM_DIR_SEL 11
`define CTRL_RESET 32'h0000_0000

// ----------------------------------------------------------------------------
// Input positions
// ----------------------------------------------------------------------------
`define IN_A 0
`define IN_B 1
`define IN_RST 2
`define IN_START 3
`define IN_SINGLE 4
`define IN_A_ALT 6
`define IN_B_ALT 7

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### design/encoder_counter_input_config.sv
`include "encoder_counter_cfg.svh"

module encoder_counter_input_config
    import encoder_counter_pkg::*;
#(
    parameter int GEN_FILT_CYC = `FILT_GEN_CYC
) (
    input wire logic core_clk, // System clock, 25 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic [7:0] fast_input, // Encoder and general input pins.
    input wire logic wdt_error, // Self-diagnosis error, level.
    output logic [7:0] outputs_q, // Output points, off on error.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read data valid.
    input wire logic s_axi_rready // Read data ready.
);
    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    logic [31:0] ctrl_q;
    logic [7:0] out_reg_q;
    logic aw_full_q, w_full_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go;
    logic [7:0] filt;
    count_t single_q, dual_q, quad_q;
    dir_t dual_dir_q, quad_dir_q;
    logic err_q;

    function automatic logic mapped(input logic [7:0] a);
        return a == `OFS_CTRL || a == `OFS_STATUS || a == `OFS_SINGLE ||
               a == `OFS_DUAL || a == `OFS_QUAD || a == `OFS_OUT;
    endfunction : mapped

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = n[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q <= `CTRL_RESET;
            out_reg_q <= '0;
        end else if (wr_go) begin
            if (awaddr_q == `OFS_CTRL) begin
                ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q);
            end
            if (awaddr_q == `OFS_OUT && wstrb_q[0]) begin
                out_reg_q <= wdata_q[7:0];
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
            unique case (s_axi_araddr)
                `OFS_CTRL: s_axi_rdata <= ctrl_q;
                `OFS_STATUS: s_axi_rdata <= {15'h0000, err_q, filt,
                                             6'h00, quad_dir_q, dual_dir_q};
                `OFS_SINGLE: s_axi_rdata <= single_q;
                `OFS_DUAL: s_axi_rdata <= dual_q;
                `OFS_QUAD: s_axi_rdata <= quad_q;
                `OFS_OUT: s_axi_rdata <= {24'h000000, out_reg_q};
                default: s_axi_rdata <= '0;
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Input filters
    // ------------------------------------------------------------------------
    logic fn_chg, rst_drop, remap;
    logic en_single, en_dual, en_quad;
    inputs_t used;

    assign fn_chg = ctrl_q[`CTRL_FN_CHANGE];
    assign rst_drop = fn_chg && ctrl_q[`CTRL_RST_DROP];
    assign remap = fn_chg && ctrl_q[`CTRL_REMAP];
    assign en_single = ctrl_q[`CTRL_EN_SINGLE];
    assign en_dual = ctrl_q[`CTRL_EN_DUAL];
    assign en_quad = ctrl_q[`CTRL_EN_QUAD];

    always_comb begin
        used = '0;
        used[`IN_SINGLE] = en_single;
        used[`IN_A] = en_dual || (en_quad && !remap);
        used[`IN_B] = en_dual || (en_quad && !remap);
        used[`IN_RST] = (en_dual || en_quad) && !rst_drop && !remap;
        used[`IN_START] = en_quad && !remap;
        used[`IN_A_ALT] = en_quad && remap;
        used[`IN_B_ALT] = en_quad && remap;
    end

    logic [`FILT_W-1:0] thr [8];
    localparam logic [7:0] SLOW_MASK = `SLOW_FILT_MASK;

    for (genvar i = 0; i < 8; i++) begin : g_filt
        localparam logic SLOW = SLOW_MASK[i];
        assign thr[i] = !used[i] ? `FILT_W'(GEN_FILT_CYC) :
                        SLOW ? `FILT_W'(`FILT_SLOW_CYC) : `FILT_W'(`FILT_FAST_CYC);
        input_filter u_filt (
            .core_clk(core_clk),
            .nrst(nrst),
            .pin(fast_input[i]),
            .thr(thr[i]),
            .level_q(filt[i])
        );
    end

    // ------------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------------
    inputs_t prev_q;
    inputs_t rise;
    logic qa, qb, qa_p, qb_p, q_ev, q_down, q_rst, q_run;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= '0;
        end else begin
            prev_q <= filt;
        end
    end

    assign rise = filt & ~prev_q;
    assign qa = remap ? filt[`IN_A_ALT] : filt[`IN_A];
    assign qb = remap ? filt[`IN_B_ALT] : filt[`IN_B];
    assign qa_p = remap ? prev_q[`IN_A_ALT] : prev_q[`IN_A];
    assign qb_p = remap ? prev_q[`IN_B_ALT] : prev_q[`IN_B];
    // Count on each A edge; B level at the edge gives the direction.
    assign q_ev = qa != qa_p;
    assign q_down = qa ? qb : !qb;
    assign q_rst = !rst_drop && !remap && filt[`IN_RST];
    assign q_run = remap || filt[`IN_START];

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            single_q <= '0;
        end else if (wr_go && awaddr_q == `OFS_SINGLE) begin
            single_q <= merge(single_q, wdata_q, wstrb_q);
        end else if (en_single && rise[`IN_SINGLE]) begin
            single_q <= ctrl_q[`CTRL_DIR_LSB] ? single_q - 32'h1 : single_q + 32'h1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            dual_q <= '0;
            dual_dir_q <= DIR_UP;
        end else if (wr_go && awaddr_q == `OFS_DUAL) begin
            dual_q <= merge(dual_q, wdata_q, wstrb_q);
        end else if (en_dual && !rst_drop && filt[`IN_RST]) begin
            dual_q <= '0;
        end else if (en_dual && rise[`IN_A] && !rise[`IN_B]) begin
            dual_q <= dual_q + 32'h1;
            dual_dir_q <= DIR_UP;
        end else if (en_dual && rise[`IN_B] && !rise[`IN_A]) begin
            dual_q <= dual_q - 32'h1;
            dual_dir_q <= DIR_DOWN;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            quad_q <= '0;
            quad_dir_q <= DIR_UP;
        end else if (wr_go && awaddr_q == `OFS_QUAD) begin
            quad_q <= merge(quad_q, wdata_q, wstrb_q);
        end else if (en_quad && q_rst) begin
            quad_q <= '0;
        end else if (en_quad && q_run && q_ev) begin
            quad_q <= q_down ? quad_q - 32'h1 : quad_q + 32'h1;
            quad_dir_q <= q_down ? DIR_DOWN : DIR_UP;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs and error
    // ------------------------------------------------------------------------
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            err_q <= 1'b0;
            outputs_q <= '0;
        end else begin
            err_q <= err_q || wdt_error;
            outputs_q <= (err_q || wdt_error) ? 8'h00 : out_reg_q;
        end
    end

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    sequence s_single_pulse;
        en_single && rise[`IN_SINGLE] && !wr_go;
    endsequence

    a_single_dir_up: assert property (@(posedge core_clk) disable iff (!nrst)
        (s_single_pulse and !ctrl_q[`CTRL_DIR_LSB]) |=> single_q == $past(single_q) + 32'h1)
        else $error("single counter did not count up");
    a_single_dir_down: assert property (@(posedge core_clk) disable iff (!nrst)
        (s_single_pulse and ctrl_q[`CTRL_DIR_LSB]) |=> single_q == $past(single_q) - 32'h1)
        else $error("single counter did not count down");
    a_quad_dir_status: assert property (@(posedge core_clk) disable iff (!nrst)
        en_quad && q_run && q_ev && !q_rst && !wr_go |=> quad_dir_q == dir_t'($past(q_down)))
        else $error("quadrature direction status wrong");
    a_switch_needs_global: assert property (@(posedge core_clk) disable iff (!nrst)
        !fn_chg |-> !rst_drop && !remap)
        else $error("switch active without global change bit");
    a_reset_dropped: assert property (@(posedge core_clk) disable iff (!nrst)
        rst_drop && en_dual && !wr_go && !rise[`IN_A] && !rise[`IN_B]
        |=> dual_q == $past(dual_q))
        else $error("dual counter changed with reset dropped");
    a_remap_phase: assert property (@(posedge core_clk) disable iff (!nrst)
        remap |-> qa == filt[`IN_A_ALT] && qb == filt[`IN_B_ALT] && !used[`IN_RST])
        else $error("remapped quadrature phases wrong");
    a_counter_filter: assert property (@(posedge core_clk) disable iff (!nrst)
        used[`IN_SINGLE] |-> thr[`IN_SINGLE] == `FILT_W'(`FILT_FAST_CYC))
        else $error("counter input filter not fixed");
    a_general_filter: assert property (@(posedge core_clk) disable iff (!nrst)
        !used[`IN_A_ALT] |-> thr[`IN_A_ALT] == `FILT_W'(GEN_FILT_CYC))
        else $error("general input filter wrong");
    a_error_outputs_off: assert property (@(posedge core_clk) disable iff (!nrst)
        wdt_error |=> (outputs_q == 8'h00) [*2])
        else $error("outputs not off after error");
    a_quad_prompt: assert property (@(posedge core_clk) disable iff (!nrst)
        en_quad && q_run && q_ev && !q_rst && !wr_go |=> quad_q != $past(quad_q))
        else $error("quadrature count not updated on pulse");
endmodule : encoder_counter_input_config

// ### design/encoder_counter_pkg.sv
package encoder_counter_pkg;
    typedef logic [31:0] count_t;
    typedef logic [7:0] inputs_t;
    typedef enum logic {DIR_UP, DIR_DOWN} dir_t;
endpackage : encoder_counter_pkg

// ### design/input_filter.sv
`include "encoder_counter_cfg.svh"

module input_filter (
    input wire logic core_clk, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic pin, // Raw input pin.
    input wire logic [`FILT_W-1:0] thr, // Cycles of stability required.
    output logic level_q // Filtered level.
);
    logic meta_q;
    logic sync_q;
    logic [`FILT_W-1:0] cnt_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end

    // A change is accepted only after it has held for thr cycles.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            level_q <= 1'b0;
        end else if (sync_q == level_q) begin
            cnt_q <= '0;
        end else if (cnt_q >= thr - `FILT_W'(1)) begin
            cnt_q <= '0;
            level_q <= sync_q;
        end else begin
            cnt_q <= cnt_q + `FILT_W'(1);
        end
    end
endmodule : input_filter

// ### dv/quad_encoder_model.sv
module quad_encoder_model (
    input wire logic core_clk, // Step timing clock.
    input wire logic nrst, // Reset, active low.
    input wire logic start, // Begins a run of quarter steps.
    input wire logic reverse, // High turns the shaft backwards.
    input wire logic [7:0] n_steps, // Quarter steps in the run.
    input wire logic [11:0] hold, // Cycles each phase state stands, less one.
    output logic busy_q, // High while stepping.
    output logic phase_a, // Phase A output.
    output logic phase_b // Phase B output.
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------------
    // Shaft position and phase outputs
    // ------------------------------------------------------------------------
    logic [1:0] pos_q;
    logic [7:0] left_q;
    logic [11:0] cnt_q;

    assign phase_a = pos_q[0] ^ pos_q[1];
    assign phase_b = pos_q[1];

    // Each state stands for hold + 1 cycles, so the pulse rate stays in range.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pos_q <= 2'd0;
            left_q <= 8'h00;
            cnt_q <= 12'h000;
            busy_q <= 1'b0;
        end else if (start && !busy_q) begin
            left_q <= n_steps;
            cnt_q <= hold;
            busy_q <= n_steps != 8'h00;
        end else if (busy_q) begin
            if (cnt_q != 12'h000) begin
                cnt_q <= cnt_q - 12'h001;
            end else begin
                pos_q <= reverse ? pos_q - 2'd1 : pos_q + 2'd1;
                left_q <= left_q - 8'h01;
                cnt_q <= hold;
                busy_q <= left_q != 8'h01;
            end
        end
    end
endmodule : quad_encoder_model

// ### dv/tb_top.sv
`include "encoder_counter_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic core_clk, nrst, wdt_error, e_start, e_rev, e_busy, e_a, e_b;
    logic [7:0] pins_q, fast_input, outputs_q, s_axi_awaddr, s_axi_araddr, e_n;
    logic [31:0] s_axi_wdata, s_axi_rdata, v, exp;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, route;
    logic [11:0] e_hold;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int fails, n_tests, cyc, seed, n, m;

    encoder_counter_input_config #(.GEN_FILT_CYC(300)) i_dut (.core_clk, .nrst,
        .fast_input, .wdt_error, .outputs_q, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    quad_encoder_model i_enc (.core_clk, .nrst, .start(e_start), .reverse(e_rev),
        .n_steps(e_n), .hold(e_hold), .busy_q(e_busy), .phase_a(e_a), .phase_b(e_b));

    // The encoder owns its two pins alone; with control 0x1e they feed both the dual and the quad counter.
    always_comb begin
        fast_input = pins_q;
        if (route == 2'd1) begin
            fast_input[`IN_A] = e_a;
            fast_input[`IN_B] = e_b;
        end
        if (route == 2'd2) begin
            fast_input[`IN_A_ALT] = e_a;
            fast_input[`IN_B_ALT] = e_b;
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            fails++;
            stop_test();
        end
    end

    // ------------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------------
    task automatic stop_test();
        if (fails == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] got, input logic [31:0] want);
        n_tests++;
        if (got !== want) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            k++;
        end while (!s_axi_bvalid && k < 100);
        s_axi_bready <= 1'b0;
        check({s_axi_bvalid, s_axi_bresp}, {1'b1, er});
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
        int k;
        k = 0;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            k++;
        end while (!s_axi_rvalid && k < 100);
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        check({s_axi_rvalid, s_axi_rresp}, {1'b1, er});
    endtask : rd

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d, `RESP_OKAY);
        check(d, e);
    endtask : rc

    task automatic st(input int b, input logic e);
        logic [31:0] d;
        rd(`OFS_STATUS, d, `RESP_OKAY);
        check(d[b], e);
    endtask : st

    task automatic pulse(input int b, input int hi);
        @(posedge core_clk);
        pins_q[b] <= 1'b1;
        repeat (hi) @(posedge core_clk);
        pins_q[b] <= 1'b0;
        repeat (300) @(posedge core_clk);
    endtask : pulse

    function automatic int qdelta(input logic rv, input int steps);
        logic [1:0] p, nx;
        int d;
        p = 2'd0;
        d = 0;
        for (int i = 0; i < steps; i++) begin
            nx = rv ? p - 2'd1 : p + 2'd1;
            if ((nx[0] ^ nx[1]) != (p[0] ^ p[1])) d += ((nx[0] ^ nx[1]) != nx[1]) ? 1 : -1;
            p = nx;
        end
        return d;
    endfunction : qdelta

    task automatic turn(input logic rv, input int hold, input logic counts);
        int k, steps;
        steps = 4 * (1 + $unsigned($random(seed)) % 2);
        k = 0;
        @(posedge core_clk);
        e_rev <= rv;
        e_n <= steps[7:0];
        e_hold <= hold[11:0];
        e_start <= 1'b1;
        @(posedge core_clk);
        e_start <= 1'b0;
        @(posedge core_clk);
        while (e_busy && k < 20000) begin
            @(posedge core_clk);
            k++;
        end
        repeat (hold + 300) @(posedge core_clk);
        if (counts) exp = exp + qdelta(rv, steps);
    endtask : turn

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        seed = 32'hdcfb;
        {fails, n_tests, cyc, exp} = '0;
        {nrst, wdt_error, pins_q, route, e_start, e_rev, e_n, e_hold} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rc(`OFS_CTRL, `CTRL_RESET);
        rc(`OFS_QUAD, 32'h0);
        rd(8'h40, v, `RESP_SLVERR);
        check(v, 32'h0);
        wr(8'h40, 32'h1, `RESP_SLVERR);
        n = 1 + $unsigned($random(seed)) % 6;
        m = 1 + $unsigned($random(seed)) % 4;
        wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
        repeat (n) pulse(`IN_SINGLE, 280);
        pulse(`IN_SINGLE, 200);
        rc(`OFS_SINGLE, n);
        wr(`OFS_CTRL, 32'h1 | (32'h1 << `CTRL_DIR_LSB), `RESP_OKAY);
        repeat (m) pulse(`IN_SINGLE, 280);
        rc(`OFS_SINGLE, n - m);
        wr(`OFS_CTRL, 32'h2, `RESP_OKAY);
        repeat (n) pulse(`IN_A, 280);
        st(0, 1'b0);
        pulse(`IN_B, 280);
        st(0, 1'b1);
        rc(`OFS_DUAL, n - 1);
        route <= 2'd1;
        pins_q[`IN_START] <= 1'b1;
        wr(`OFS_CTRL, 32'h4, `RESP_OKAY);
        repeat (300) @(posedge core_clk);
        turn(1'b0, 300, 1'b1);
        rc(`OFS_QUAD, exp);
        st(1, 1'b0);
        turn(1'b1, 300, 1'b1);
        rc(`OFS_QUAD, exp);
        st(1, 1'b1);
        pulse(`IN_RST, 1000);
        rc(`OFS_QUAD, exp);
        pulse(`IN_RST, 1300);
        exp = 0;
        rc(`OFS_QUAD, exp);
        pins_q[`IN_RST] <= 1'b1;
        wr(`OFS_CTRL, 32'h1e, `RESP_OKAY);
        repeat (1400) @(posedge core_clk);
        turn(1'b0, 300, 1'b1);
        rc(`OFS_QUAD, exp);
        rc(`OFS_DUAL, n - 1);
        wr(`OFS_CTRL, 32'h14, `RESP_OKAY);
        repeat (1400) @(posedge core_clk);
        exp = 0;
        rc(`OFS_QUAD, exp);
        pins_q[`IN_RST] <= 1'b0;
        route <= 2'd2;
        wr(`OFS_CTRL, 32'h24, `RESP_OKAY);
        repeat (1400) @(posedge core_clk);
        turn(1'b0, 1300, 1'b0);
        rc(`OFS_QUAD, exp);
        pins_q[`IN_RST] <= 1'b1;
        pins_q[`IN_START] <= 1'b0;
        wr(`OFS_CTRL, 32'h2c, `RESP_OKAY);
        repeat (1400) @(posedge core_clk);
        turn(1'b0, 1300, 1'b1);
        rc(`OFS_QUAD, exp);
        turn(1'b1, 1300, 1'b1);
        rc(`OFS_QUAD, exp);
        st(1, 1'b1);
        pins_q[5] <= 1'b1;
        repeat (250) @(posedge core_clk);
        st(13, 1'b0);
        repeat (80) @(posedge core_clk);
        st(13, 1'b1);
        v = $random(seed) | 32'h1;
        wr(`OFS_OUT, v, `RESP_OKAY);
        @(posedge core_clk);
        check(outputs_q, v[7:0]);
        wdt_error <= 1'b1;
        repeat (2) @(posedge core_clk);
        check(outputs_q, 8'h00);
        wdt_error <= 1'b0;
        wr(`OFS_OUT, 32'hff, `RESP_OKAY);
        check(outputs_q, 8'h00);
        st(16, 1'b1);
        stop_test();
    end
endmodule : tb_top
